/* File: copr_pkg.sv */
// constants for the charger option and processor-hot threshold register bank
package copr_pkg;

  // byte addresses on the serial register port, low byte even, high byte odd
  localparam logic [7:0]  ADDR_OPT_LO         = 8'h34;
  localparam logic [7:0]  ADDR_OPT_HI         = 8'h35;
  localparam logic [7:0]  ADDR_THR_LO         = 8'h36;
  localparam logic [7:0]  ADDR_THR_HI         = 8'h37;
  localparam logic [7:0]  UNMAPPED_DATA       = 8'h00;

  // reset values
  localparam logic [15:0] OPT_RESET           = 16'h0030;
  localparam logic [15:0] THR_RESET           = 16'h4a65;

  // charge control options field positions
  localparam int          OPT_HIZ             = 15;
  localparam int          OPT_RESTORE         = 14;
  localparam int          OPT_REMEASURE       = 13;
  localparam int          OPT_REVERSE_EN      = 12;
  localparam int          OPT_OPTIMIZER_EN    = 11;
  localparam int          OPT_CONSERVATIVE    = 6;
  localparam int          OPT_SHARED_PIN      = 5;
  localparam int          OPT_CLAMP_LSB       = 3;
  localparam int          OPT_RANGE_LOW       = 2;
  localparam int          OPT_BATT_OFF        = 1;
  localparam int          OPT_POWER_REPORT    = 0;
  localparam logic [15:0] OPT_RESTORE_MASK    = 16'h4000;
  localparam logic [15:0] OPT_REMEASURE_MASK  = 16'h2000;

  // processor-hot thresholds field positions
  localparam int          THR_SECOND_CURRENT_LIMIT_LSB       = 11;
  localparam int          THR_CRIT_DEG_LSB    = 9;
  localparam int          THR_RATIO           = 8;
  localparam int          THR_TH1_LSB         = 4;
  localparam int          THR_TH2_LSB         = 2;
  localparam int          THR_NOM_DEG         = 1;
  localparam int          THR_LOWER_EN        = 0;

  // alarm source indexes
  localparam int          SRC_LOW_VOLTAGE     = 0;
  localparam int          SRC_CRITICAL        = 1;
  localparam int          SRC_NOMINAL         = 2;
  localparam int          SRC_SYSTEM          = 3;
  localparam int          SRC_COUNT           = 4;

  // inductor clamp levels in mA
  localparam logic [13:0] CLAMP_MA_0          = 14'd6000;
  localparam logic [13:0] CLAMP_MA_1          = 14'd10000;
  localparam logic [13:0] CLAMP_MA_2          = 14'd15000;
  localparam logic [1:0]  CLAMP_OFF_CODE      = 2'h3;

  // second current limit percentages
  localparam logic [9:0]  SECOND_CURRENT_LIMIT_FINE_BASE     = 10'd105;
  localparam logic [9:0]  SECOND_CURRENT_LIMIT_FINE_STEP     = 10'd5;
  localparam logic [4:0]  SECOND_CURRENT_LIMIT_FINE_LAST     = 5'h19;
  localparam logic [4:0]  SECOND_CURRENT_LIMIT_COARSE_FIRST  = 5'h1a;
  localparam logic [9:0]  SECOND_CURRENT_LIMIT_COARSE_BASE   = 10'd250;
  localparam logic [9:0]  SECOND_CURRENT_LIMIT_COARSE_STEP   = 10'd50;
  localparam logic [4:0]  SECOND_CURRENT_LIMIT_IGNORED       = 5'h1f;
  localparam logic [9:0]  SECOND_CURRENT_LIMIT_RESET_PCT     = 10'd150;
  localparam logic [13:0] MARGIN_NUM          = 14'd11;
  localparam logic [13:0] MARGIN_DEN          = 14'd10;

  // system voltage thresholds in mV
  localparam logic [12:0] MULTI_CELL_BASE_MV  = 13'd5900;
  localparam logic [12:0] ONE_CELL_BASE_MV    = 13'd3100;
  localparam logic [12:0] TH1_STEP_MV         = 13'd100;
  localparam logic [12:0] TH2_MULTI_STEP_MV   = 13'd300;
  localparam logic [12:0] TH2_ONE_STEP_MV     = 13'd200;

  // low voltage alarm percentages of the input voltage limit
  localparam logic [6:0]  LV_FOLLOW_PCT       = 7'd100;
  localparam logic [6:0]  LV_LOW_PCT          = 7'd80;
  localparam logic [6:0]  LV_HIGH_PCT         = 7'd90;

  // deglitch timing
  localparam int          DEG_WIDTH           = 23;
  localparam int          CLK_PERIOD_NS       = 10;
  localparam int          SYS_DEG_NS          = 5000;
  localparam int          CRIT_DEG0_NS        = 15000;
  localparam int          CRIT_DEG1_NS        = 100000;
  localparam int          CRIT_DEG2_NS        = 400000;
  localparam int          CRIT_DEG3_NS        = 800000;
  localparam int          NOM_DEG0_NS         = 1000000;
  localparam int          NOM_DEG1_NS         = 50000000;
  localparam int          SYS_DEG_CYC         = (SYS_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CRIT_DEG0_CYC       = (CRIT_DEG0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CRIT_DEG1_CYC       = (CRIT_DEG1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CRIT_DEG2_CYC       = (CRIT_DEG2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CRIT_DEG3_CYC       = (CRIT_DEG3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          NOM_DEG0_CYC        = (NOM_DEG0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          NOM_DEG1_CYC        = (NOM_DEG1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* File: copr_deglitch.sv */
// persistence filter: output rises once the input has held high for limit cycles
`timescale 1ns/1ps
module copr_deglitch (
  // clock and reset
  input  wire logic                         clk_sys_i,
  input  wire logic                         reset_i,
  // level and hold time
  input  wire logic                         level_i,
  input  wire logic [copr_pkg::DEG_WIDTH-1:0] limit_i,
  // filtered level
  output logic                              qualified_o
);

  logic [copr_pkg::DEG_WIDTH-1:0] count;
  logic [copr_pkg::DEG_WIDTH-1:0] next_count;
  logic                           held;

  // saturating count of consecutive high cycles
  assign held       = (count >= limit_i);
  assign next_count = !level_i ? '0 : (held ? count : count + 1'b1);

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      count       <= '0;
      qualified_o <= 1'b0;
    end else begin
      count       <= next_count;
      qualified_o <= level_i && (next_count >= limit_i);
    end
  end

endmodule // copr_deglitch

/* File: copr_regs.sv */
// charger option and processor-hot threshold register bank with alarm logic
`timescale 1ns/1ps
//
// Contract
// - high-impedance bit set puts device in low-current idle, battery feeds system
// - writing restore bit reloads all registers but input voltage limit, then reads zero
// - remeasure bit disables converter until measurement done, then clears itself
// - reverse-power and input-optimizer enables follow their bits, both reset to zero
// - conservative select picks system or bus undervoltage trigger, gated by alarm enable
// - shared pin drives min-voltage protection at 0, reverse power at 1
// - clamp code selects 6A, 10A, 15A, or disabled
// - reverse voltage low-range bit selects 3V or 4.28V based output range
// - battery-switch-off bit turns battery switch off during high-impedance mode
// - in reverse power, report select picks discharge-only or net power report
// - second current limit code maps to percent; code 11111 ignored; code 00000 is also ignored here, limit holds
// - critical level is 110 percent of limit, with selectable deglitch
// - low-voltage alarm threshold follows register or is 80/90 percent
// - in protection mode, system below first threshold 5us discharges input bus
// - system below second threshold 5us asserts system voltage alarm source
// - nominal event after current above 110 percent for 1ms or 50ms
// - masked alarm sources neither pull the alarm nor set status
// - entering min-voltage protection mode sets system voltage alarm enable
module copr_regs #(
  parameter logic [copr_pkg::DEG_WIDTH-1:0] CRIT_DEG1_CYC = copr_pkg::DEG_WIDTH'(copr_pkg::CRIT_DEG1_CYC),
  parameter logic [copr_pkg::DEG_WIDTH-1:0] CRIT_DEG2_CYC = copr_pkg::DEG_WIDTH'(copr_pkg::CRIT_DEG2_CYC),
  parameter logic [copr_pkg::DEG_WIDTH-1:0] CRIT_DEG3_CYC = copr_pkg::DEG_WIDTH'(copr_pkg::CRIT_DEG3_CYC),
  parameter logic [copr_pkg::DEG_WIDTH-1:0] NOM_DEG0_CYC  = copr_pkg::DEG_WIDTH'(copr_pkg::NOM_DEG0_CYC),
  parameter logic [copr_pkg::DEG_WIDTH-1:0] NOM_DEG1_CYC  = copr_pkg::DEG_WIDTH'(copr_pkg::NOM_DEG1_CYC)
) (
  // clock and reset
  input  wire logic                         clk_sys_i,
  input  wire logic                         reset_i,
  // byte register port from the serial engine
  input  wire logic [7:0]                   reg_addr_i,
  input  wire logic                         reg_wr_i,
  input  wire logic [7:0]                   reg_wdata_i,
  input  wire logic                         reg_rd_i,
  output logic      [7:0]                   reg_rdata_o,
  // analog and pin status
  input  wire logic                         one_cell_i,
  input  wire logic                         shared_pin_i,
  input  wire logic                         measure_done_i,
  input  wire logic                         sys_below_th1_i,
  input  wire logic                         sys_below_th2_i,
  input  wire logic                         bus_below_convenz_i,
  input  wire logic                         low_input_voltage_i,
  input  wire logic                         current_above_critical_i,
  input  wire logic                         current_above_nominal_i,
  // alarm mask and status clear from the neighbouring alarm registers
  input  wire logic [copr_pkg::SRC_COUNT-1:0] source_mask_i,
  input  wire logic [copr_pkg::SRC_COUNT-1:0] status_clear_i,
  // power path controls
  output logic                              high_impedance_mode_o,
  output logic                              battery_switch_off_o,
  output logic                              restore_defaults_o,
  output logic                              converter_disable_o,
  output logic                              reverse_power_mode_o,
  output logic                              input_optimizer_enable_o,
  output logic                              min_voltage_protect_mode_o,
  output logic                              reverse_voltage_low_range_o,
  output logic                              power_report_discharge_only_o,
  output logic      [13:0]                  inductor_clamp_ma_o,
  output logic                              inductor_clamp_disable_o,
  output logic                              input_bus_discharge_o,
  // thresholds
  output logic      [9:0]                   second_current_limit_pct_o,
  output logic      [9:0]                   critical_current_pct_o,
  output logic      [12:0]                  system_discharge_threshold_mv_o,
  output logic      [12:0]                  system_alarm_threshold_mv_o,
  output logic      [6:0]                   low_voltage_alarm_pct_o,
  // alarm
  output logic                              system_voltage_alarm_source_o,
  output logic                              system_voltage_alarm_enable_set_o,
  output logic      [copr_pkg::SRC_COUNT-1:0] alarm_status_o,
  output logic                              processor_hot_alarm_n_o
);

  // threshold in mV from base, step and code
  function automatic logic [12:0] thr_mv(input logic [12:0] base, input logic [12:0] step, input logic [3:0] code);
    logic [16:0] prod;
    prod   = step * code;
    thr_mv = base + prod[12:0];
  endfunction

  logic [15:0] opt;
  logic [15:0] thr;
  logic [15:0] opt_written;
  logic [15:0] thr_written;
  logic [15:0] next_opt;
  logic [15:0] next_thr;
  logic        wr_opt_lo;
  logic        wr_opt_hi;
  logic        wr_thr_lo;
  logic        wr_thr_hi;
  logic        restore_req;
  logic        remeasure_next;
  logic [7:0]  read_byte;

  // byte decode
  assign wr_opt_lo = reg_wr_i && (reg_addr_i == copr_pkg::ADDR_OPT_LO);
  assign wr_opt_hi = reg_wr_i && (reg_addr_i == copr_pkg::ADDR_OPT_HI);
  assign wr_thr_lo = reg_wr_i && (reg_addr_i == copr_pkg::ADDR_THR_LO);
  assign wr_thr_hi = reg_wr_i && (reg_addr_i == copr_pkg::ADDR_THR_HI);

  assign opt_written = {wr_opt_hi ? reg_wdata_i : opt[15:8], wr_opt_lo ? reg_wdata_i : opt[7:0]};
  assign thr_written = {wr_thr_hi ? reg_wdata_i : thr[15:8], wr_thr_lo ? reg_wdata_i : thr[7:0]};

  // restore is a one-shot request, never stored
  assign restore_req = wr_opt_hi && reg_wdata_i[copr_pkg::OPT_RESTORE - 8];

  // remeasure holds until done; a fresh write wins over done
  assign remeasure_next = wr_opt_hi ? reg_wdata_i[copr_pkg::OPT_REMEASURE - 8]
                                    : (opt[copr_pkg::OPT_REMEASURE] && !measure_done_i);

  assign next_opt = (opt_written & ~(copr_pkg::OPT_RESTORE_MASK | copr_pkg::OPT_REMEASURE_MASK))
                  | (remeasure_next ? copr_pkg::OPT_REMEASURE_MASK : 16'h0000);
  assign next_thr = thr_written;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || restore_req) begin
      opt <= copr_pkg::OPT_RESET;
      thr <= copr_pkg::THR_RESET;
    end else begin
      opt <= next_opt;
      thr <= next_thr;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      restore_defaults_o <= 1'b0;
    end else begin
      restore_defaults_o <= restore_req;
    end
  end

  // read mux, unmapped bytes read zero
  assign read_byte = (reg_addr_i == copr_pkg::ADDR_OPT_LO) ? opt[7:0]  :
                     (reg_addr_i == copr_pkg::ADDR_OPT_HI) ? opt[15:8] :
                     (reg_addr_i == copr_pkg::ADDR_THR_LO) ? thr[7:0]  :
                     (reg_addr_i == copr_pkg::ADDR_THR_HI) ? thr[15:8] :
                     copr_pkg::UNMAPPED_DATA;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= read_byte;
    end
  end

  // power path decode
  logic [1:0] clamp_code;
  logic       pin_selects_reverse;

  assign high_impedance_mode_o       = opt[copr_pkg::OPT_HIZ];
  assign battery_switch_off_o        = opt[copr_pkg::OPT_HIZ] && opt[copr_pkg::OPT_BATT_OFF];
  assign converter_disable_o         = opt[copr_pkg::OPT_REMEASURE] || opt[copr_pkg::OPT_HIZ];
  assign pin_selects_reverse         = opt[copr_pkg::OPT_SHARED_PIN];
  assign reverse_power_mode_o        = opt[copr_pkg::OPT_REVERSE_EN]
                                     && (!pin_selects_reverse || shared_pin_i);
  assign min_voltage_protect_mode_o  = !pin_selects_reverse && shared_pin_i;
  assign input_optimizer_enable_o    = opt[copr_pkg::OPT_OPTIMIZER_EN];
  assign reverse_voltage_low_range_o = opt[copr_pkg::OPT_RANGE_LOW];
  assign power_report_discharge_only_o = reverse_power_mode_o && opt[copr_pkg::OPT_POWER_REPORT];

  assign clamp_code               = opt[copr_pkg::OPT_CLAMP_LSB +: 2];
  assign inductor_clamp_disable_o = (clamp_code == copr_pkg::CLAMP_OFF_CODE);
  assign inductor_clamp_ma_o      = (clamp_code == 2'h0) ? copr_pkg::CLAMP_MA_0 :
                                    (clamp_code == 2'h1) ? copr_pkg::CLAMP_MA_1 :
                                    copr_pkg::CLAMP_MA_2;

  // second current limit and critical level
  logic [4:0]  second_current_limit_code;
  logic        second_current_limit_valid;
  logic [9:0]  second_current_limit_pct;
  logic [9:0]  fine_pct;
  logic [9:0]  coarse_pct;
  logic [13:0] crit_scaled;

  assign second_current_limit_code  = thr[copr_pkg::THR_SECOND_CURRENT_LIMIT_LSB +: 5];
  assign second_current_limit_valid = (second_current_limit_code != copr_pkg::SECOND_CURRENT_LIMIT_IGNORED) && (second_current_limit_code != 5'h00);
  assign fine_pct    = copr_pkg::SECOND_CURRENT_LIMIT_FINE_BASE + copr_pkg::SECOND_CURRENT_LIMIT_FINE_STEP * {5'h00, second_current_limit_code};
  assign coarse_pct  = copr_pkg::SECOND_CURRENT_LIMIT_COARSE_BASE
                     + copr_pkg::SECOND_CURRENT_LIMIT_COARSE_STEP * {5'h00, second_current_limit_code - copr_pkg::SECOND_CURRENT_LIMIT_COARSE_FIRST};
  assign second_current_limit_pct   = (second_current_limit_code <= copr_pkg::SECOND_CURRENT_LIMIT_FINE_LAST) ? fine_pct : coarse_pct;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      second_current_limit_pct_o <= copr_pkg::SECOND_CURRENT_LIMIT_RESET_PCT;
    end else if (second_current_limit_valid) begin
      second_current_limit_pct_o <= second_current_limit_pct;
    end
  end

  assign crit_scaled            = ({4'h0, second_current_limit_pct_o} * copr_pkg::MARGIN_NUM) / copr_pkg::MARGIN_DEN;
  assign critical_current_pct_o = crit_scaled[9:0];

  // system voltage thresholds
  logic [3:0] th1_code;
  logic [3:0] th2_code;

  assign th1_code = thr[copr_pkg::THR_TH1_LSB +: 4];
  assign th2_code = {2'h0, thr[copr_pkg::THR_TH2_LSB +: 2]};
  assign system_discharge_threshold_mv_o = one_cell_i
    ? thr_mv(copr_pkg::ONE_CELL_BASE_MV, copr_pkg::TH1_STEP_MV, {1'b0, th1_code[2:0]})
    : thr_mv(copr_pkg::MULTI_CELL_BASE_MV, copr_pkg::TH1_STEP_MV, th1_code);
  assign system_alarm_threshold_mv_o = one_cell_i
    ? thr_mv(copr_pkg::ONE_CELL_BASE_MV, copr_pkg::TH2_ONE_STEP_MV, th2_code)
    : thr_mv(copr_pkg::MULTI_CELL_BASE_MV, copr_pkg::TH2_MULTI_STEP_MV, th2_code);

  // low voltage alarm threshold
  assign low_voltage_alarm_pct_o = !thr[copr_pkg::THR_LOWER_EN] ? copr_pkg::LV_FOLLOW_PCT :
                                   thr[copr_pkg::THR_RATIO]     ? copr_pkg::LV_HIGH_PCT   :
                                   copr_pkg::LV_LOW_PCT;

  // deglitch hold times
  logic [1:0]                     crit_sel;
  logic [copr_pkg::DEG_WIDTH-1:0] crit_limit;
  logic [copr_pkg::DEG_WIDTH-1:0] nom_limit;
  logic [copr_pkg::DEG_WIDTH-1:0] sys_limit;
  logic                           th1_held;
  logic                           th2_held;
  logic                           crit_held;
  logic                           nom_held;

  assign crit_sel   = thr[copr_pkg::THR_CRIT_DEG_LSB +: 2];
  assign crit_limit = (crit_sel == 2'h0) ? copr_pkg::DEG_WIDTH'(copr_pkg::CRIT_DEG0_CYC) :
                      (crit_sel == 2'h1) ? CRIT_DEG1_CYC :
                      (crit_sel == 2'h2) ? CRIT_DEG2_CYC : CRIT_DEG3_CYC;
  assign nom_limit  = thr[copr_pkg::THR_NOM_DEG] ? NOM_DEG1_CYC : NOM_DEG0_CYC;
  assign sys_limit  = copr_pkg::DEG_WIDTH'(copr_pkg::SYS_DEG_CYC);

  copr_deglitch u_th1_deglitch (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .level_i     (sys_below_th1_i),
    .limit_i     (sys_limit),
    .qualified_o (th1_held)
  );

  copr_deglitch u_th2_deglitch (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .level_i     (sys_below_th2_i),
    .limit_i     (sys_limit),
    .qualified_o (th2_held)
  );

  copr_deglitch u_crit_deglitch (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .level_i     (current_above_critical_i),
    .limit_i     (crit_limit),
    .qualified_o (crit_held)
  );

  copr_deglitch u_nom_deglitch (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .level_i     (current_above_nominal_i),
    .limit_i     (nom_limit),
    .qualified_o (nom_held)
  );

  assign input_bus_discharge_o         = min_voltage_protect_mode_o && th1_held;
  assign system_voltage_alarm_source_o = th2_held;

  // protection mode entry sets the system voltage alarm enable
  logic protect_mode_d;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      protect_mode_d                    <= 1'b0;
      system_voltage_alarm_enable_set_o <= 1'b0;
    end else begin
      protect_mode_d                    <= min_voltage_protect_mode_o;
      system_voltage_alarm_enable_set_o <= min_voltage_protect_mode_o && !protect_mode_d;
    end
  end

  // alarm sources, mask and status
  logic [copr_pkg::SRC_COUNT-1:0] raw_event;
  logic [copr_pkg::SRC_COUNT-1:0] enabled_event;
  logic [copr_pkg::SRC_COUNT-1:0] next_status;
  logic                           system_trigger;

  assign system_trigger = opt[copr_pkg::OPT_CONSERVATIVE] ? bus_below_convenz_i : th2_held;

  assign raw_event[copr_pkg::SRC_LOW_VOLTAGE] = low_input_voltage_i;
  assign raw_event[copr_pkg::SRC_CRITICAL]    = crit_held;
  assign raw_event[copr_pkg::SRC_NOMINAL]     = nom_held;
  assign raw_event[copr_pkg::SRC_SYSTEM]      = system_trigger;

  // the system source mask bit is the system voltage alarm enable
  assign enabled_event = raw_event & source_mask_i;
  assign next_status   = (alarm_status_o & ~status_clear_i) | enabled_event;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      alarm_status_o          <= '0;
      processor_hot_alarm_n_o <= 1'b1;
    end else begin
      alarm_status_o          <= next_status;
      processor_hot_alarm_n_o <= !(|enabled_event);
    end
  end

endmodule // copr_regs

/* File: copr_regs_sva.sv */
// assertion checker for the option and alarm threshold register bank
`timescale 1ns/1ps
module copr_regs_chk (
  // clock, reset and register port
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic measure_done_i,
  // watched outputs
  input wire logic high_impedance_mode_o,
  input wire logic battery_switch_off_o,
  input wire logic restore_defaults_o,
  input wire logic converter_disable_o,
  input wire logic min_voltage_protect_mode_o,
  input wire logic [13:0] inductor_clamp_ma_o,
  input wire logic inductor_clamp_disable_o,
  input wire logic [9:0] second_current_limit_pct_o,
  input wire logic [9:0] critical_current_pct_o,
  input wire logic system_voltage_alarm_enable_set_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire hi_wr = reg_wr_i && reg_addr_i == 8'h35;
  sequence s_restore; hi_wr && reg_wdata_i[6]; endsequence
  sequence s_meas; hi_wr && reg_wdata_i[5] && !reg_wdata_i[6]; endsequence
  AST_HIZ: assert property (hi_wr && !reg_wdata_i[6] |=> high_impedance_mode_o == $past(reg_wdata_i[7]))
    else $error("idle bit not applied");
  AST_RESTORE: assert property (s_restore |-> ##[1:2] restore_defaults_o ##1 !restore_defaults_o)
    else $error("restore pulse wrong");
  AST_MEAS_SET: assert property (s_meas |=> converter_disable_o)
    else $error("converter not stopped");
  AST_MEAS_CLR: assert property (measure_done_i && !reg_wr_i && !high_impedance_mode_o |=> !converter_disable_o)
    else $error("converter not restarted");
  AST_BATT: assert property (battery_switch_off_o |-> high_impedance_mode_o)
    else $error("switch off outside idle");
  AST_CLAMP: assert property (inductor_clamp_disable_o |-> inductor_clamp_ma_o == 14'd15000)
    else $error("clamp level wrong");
  AST_CRIT: assert property ($stable(second_current_limit_pct_o) |->
    14'(critical_current_pct_o) == 14'(second_current_limit_pct_o) * 14'd11 / 14'd10) else $error("critical level wrong");
  AST_VAPSET: assert property ($rose(min_voltage_protect_mode_o) |-> ##[1:2] system_voltage_alarm_enable_set_o)
    else $error("alarm enable not set");
endmodule // copr_regs_chk
bind copr_regs copr_regs_chk chk_u (.*);

/* File: copr_host.sv */
// host model issuing byte writes and reads on the register port
`timescale 1ns/1ps
module copr_host (
  // clock
  input  wire logic       clk_sys_i,
  // register port
  output logic [7:0]      reg_addr_o = 8'h00,
  output logic            reg_wr_o = 1'b0,
  output logic [7:0]      reg_wdata_o = 8'h00,
  output logic            reg_rd_o = 1'b0,
  input  wire logic [7:0] reg_rdata_i
);
  // one byte per strobe, low byte even
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1 reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge clk_sys_i);
    #1 reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    #1 reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge clk_sys_i);
    #1 reg_rd_o = 1'b0;
    d = reg_rdata_i;
  endtask
endmodule // copr_host

/* File: tb.sv */
// self-checking bench for the option and alarm threshold register bank
`timescale 1ns/1ps
module tb;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, reg_wr_i, reg_rd_i, one_cell_i = 1'b0, shared_pin_i = 1'b0;
  logic measure_done_i = 1'b0, sys_below_th1_i = 1'b0, sys_below_th2_i = 1'b0, bus_below_convenz_i = 1'b0;
  logic low_input_voltage_i = 1'b0, current_above_critical_i = 1'b0, current_above_nominal_i = 1'b0;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd_v;
  logic [3:0] source_mask_i = 4'h0, status_clear_i = 4'h0, alarm_status_o;
  logic high_impedance_mode_o, battery_switch_off_o, restore_defaults_o, converter_disable_o, reverse_power_mode_o;
  logic input_optimizer_enable_o, min_voltage_protect_mode_o, reverse_voltage_low_range_o, input_bus_discharge_o;
  logic power_report_discharge_only_o, inductor_clamp_disable_o, system_voltage_alarm_source_o, processor_hot_alarm_n_o;
  logic system_voltage_alarm_enable_set_o;
  logic [13:0] inductor_clamp_ma_o;
  logic [9:0] second_current_limit_pct_o, critical_current_pct_o;
  logic [12:0] system_discharge_threshold_mv_o, system_alarm_threshold_mv_o;
  logic [6:0] low_voltage_alarm_pct_o;
  int num_errors = 0, checks_done = 0, cycles = 0;
  logic [15:0] rows [5] = '{16'h3430, 16'h3500, 16'h3665, 16'h374a, 16'h3800};
  copr_regs #(.CRIT_DEG1_CYC(23'd20), .NOM_DEG0_CYC(23'd30)) dut_u (.*);
  copr_host host_u (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i),
    .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  initial begin
    tick(12);
    reset_i = 1'b0;
    host_u.wr(8'h38, 8'hff);
    for (int i = 0; i < 5; i++) begin
      host_u.rd(rows[i][15:8], rd_v);
      chk(rd_v, rows[i][7:0]);
    end
    shared_pin_i = 1'b1;
    host_u.wr(8'h35, 8'h98);
    chk({high_impedance_mode_o, reverse_power_mode_o, input_optimizer_enable_o}, 3'h7);
    host_u.wr(8'h34, 8'h3f);
    chk({inductor_clamp_disable_o, battery_switch_off_o, reverse_voltage_low_range_o,
      power_report_discharge_only_o}, 4'hf);
    for (int c = 0; c < 3; c++) begin
      host_u.wr(8'h34, 8'h20 | 8'(c << 3));
      chk(inductor_clamp_ma_o, c == 0 ? 14'd6000 : c == 1 ? 14'd10000 : 14'd15000);
    end
    host_u.wr(8'h35, 8'h40);
    chk(restore_defaults_o, 1'b1);
    host_u.rd(8'h35, rd_v);
    chk({rd_v, high_impedance_mode_o}, 9'h000);
    host_u.rd(8'h34, rd_v);
    chk(rd_v, 8'h30);
    host_u.wr(8'h35, 8'h20);
    chk(converter_disable_o, 1'b1);
    measure_done_i = 1'b1;
    tick(1);
    measure_done_i = 1'b0;
    tick(1);
    chk(converter_disable_o, 1'b0);
    host_u.wr(8'h37, 8'hd4);
    tick(1);
    chk({second_current_limit_pct_o, critical_current_pct_o}, {10'd250, 10'd275});
    host_u.wr(8'h37, 8'hfc);
    tick(1);
    chk(second_current_limit_pct_o, 10'd250);
    host_u.wr(8'h36, 8'h6c);
    chk({system_discharge_threshold_mv_o, system_alarm_threshold_mv_o, low_voltage_alarm_pct_o},
      {13'd6500, 13'd6800, 7'd100});
    host_u.wr(8'h34, 8'h10);
    tick(1);
    chk({min_voltage_protect_mode_o, system_voltage_alarm_enable_set_o}, 2'h3);
    source_mask_i = 4'h8;
    sys_below_th1_i = 1'b1;
    sys_below_th2_i = 1'b1;
    tick(495);
    chk({system_voltage_alarm_source_o, processor_hot_alarm_n_o}, 2'h1);
    tick(10);
    chk({system_voltage_alarm_source_o, input_bus_discharge_o, processor_hot_alarm_n_o,
      alarm_status_o}, 7'h68);
    source_mask_i = 4'h0;
    status_clear_i = 4'hf;
    tick(1);
    status_clear_i = 4'h0;
    tick(3);
    chk({processor_hot_alarm_n_o, alarm_status_o}, 5'h10);
    one_cell_i = 1'b1;
    host_u.wr(8'h36, 8'hed);
    host_u.wr(8'h37, 8'h0d);
    tick(1);
    chk({system_discharge_threshold_mv_o, system_alarm_threshold_mv_o, low_voltage_alarm_pct_o,
      second_current_limit_pct_o}, {13'd3700, 13'd3700, 7'd90, 10'd110});
    one_cell_i = 1'b0;
    host_u.wr(8'h34, 8'h50);
    source_mask_i = 4'h8;
    tick(2);
    chk({processor_hot_alarm_n_o, alarm_status_o}, 5'h10);
    bus_below_convenz_i = 1'b1;
    tick(2);
    chk({processor_hot_alarm_n_o, alarm_status_o}, 5'h08);
    bus_below_convenz_i = 1'b0;
    sys_below_th1_i = 1'b0;
    sys_below_th2_i = 1'b0;
    reset_i = 1'b1;
    tick(1);
    reset_i = 1'b0;
    chk({processor_hot_alarm_n_o, alarm_status_o, reg_rdata_o, second_current_limit_pct_o, low_voltage_alarm_pct_o},
      {5'h10, 8'h00, 10'd150, 7'd80});
    source_mask_i = 4'h6;
    low_input_voltage_i = 1'b1;
    current_above_critical_i = 1'b1;
    current_above_nominal_i = 1'b1;
    tick(19);
    chk({processor_hot_alarm_n_o, alarm_status_o}, 5'h10);
    tick(2);
    chk({processor_hot_alarm_n_o, alarm_status_o}, 5'h02);
    tick(10);
    chk({processor_hot_alarm_n_o, alarm_status_o}, 5'h06);
    give_verdict();
  end
endmodule // tb
